// file: pkg/cefm_consts.svh
// Offsets, field positions and reset values of the charger event flag and mask bank.
`ifndef CEFM_CONSTS_SVH
`define CEFM_CONSTS_SVH

`define CEFM_OFS_CHARGE_FLAGS 8'h03
`define CEFM_OFS_FAULT_FLAGS  8'h04
`define CEFM_OFS_CONV_FLAGS   8'h05
`define CEFM_OFS_TIMER_FLAGS  8'h06
`define CEFM_OFS_CHARGE_MASKS 8'h07
`define CEFM_OFS_FAULT_MASKS  8'h08
`define CEFM_OFS_CONV_MASKS   8'h09

`define CEFM_FLAG_RESET       8'h00
`define CEFM_CHARGE_MASK_RST  8'h00
`define CEFM_FAULT_MASK_RST   8'h00
`define CEFM_CONV_MASK_RST    8'h71

`define CEFM_CHARGE_VALID     8'h7F
`define CEFM_FAULT_VALID      8'hBF
`define CEFM_CONV_VALID       8'hF1
`define CEFM_TIMER_VALID      8'h77

`define CEFM_BIT_WATCHDOG     6
`define CEFM_BIT_SAFETY       5
`define CEFM_BIT_REG_OC       4
`define CEFM_BIT_WAKE_FIRST   2
`define CEFM_BIT_WAKE_SECOND  1
`define CEFM_BIT_RESET_WARN   0

`endif

// file: pkg/cefm_pkg.sv
// Types shared by the charger event flag and mask bank.
`default_nettype none
package cefm_pkg;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cefm_req_t;

  typedef struct packed {
    logic watchdog_expired_flag;
    logic safety_timer_expired_flag;
    logic regulator_overcurrent_flag;
    logic button_wake_first_flag;
    logic button_wake_second_flag;
    logic button_reset_warning_flag;
  } cefm_timer_ev_t;

  typedef logic [3:0][7:0] cefm_bytes_t;

endpackage
`default_nettype wire

// file: hw/cefm_bank.sv
// Charger event flag registers, mask registers and interrupt request.
`include "cefm_consts.svh"
`default_nettype none
module cefm_bank
  import cefm_pkg::*;
(
  // Clock and reset.
  input  wire logic           clk,
  input  wire logic           reset,
  // Register access from the serial bus engine.
  input  wire cefm_req_t      req,
  output logic         [7:0]  rdata_q,
  output logic                rvalid_q,
  // Event pulses.
  input  wire logic    [7:0]  charge_ev,
  input  wire logic    [7:0]  fault_ev,
  input  wire logic    [7:0]  conv_ev,
  input  wire cefm_timer_ev_t timer_ev,
  // Interrupt request to the host.
  output logic                irq_q
);

  // ********************************************************
  // Flag registers.
  // ********************************************************
  localparam cefm_bytes_t FLAG_VALID = {`CEFM_TIMER_VALID, `CEFM_CONV_VALID,
                                        `CEFM_FAULT_VALID, `CEFM_CHARGE_VALID};

  logic        [7:0] flag_q [4];
  logic        [7:0] flag_d [4];
  logic        [7:0] pend_vec [4];
  logic        [7:0] mask_q [3];
  logic        [7:0] timer_vec;
  logic              irq_d;
  cefm_bytes_t       ev_vec;
  wire logic   [3:0] rd_hit;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  always_comb
  begin
    timer_vec                        = 8'h00;
    timer_vec[`CEFM_BIT_WATCHDOG]    = timer_ev.watchdog_expired_flag;
    timer_vec[`CEFM_BIT_SAFETY]      = timer_ev.safety_timer_expired_flag;
    timer_vec[`CEFM_BIT_REG_OC]      = timer_ev.regulator_overcurrent_flag;
    timer_vec[`CEFM_BIT_WAKE_FIRST]  = timer_ev.button_wake_first_flag;
    timer_vec[`CEFM_BIT_WAKE_SECOND] = timer_ev.button_wake_second_flag;
    timer_vec[`CEFM_BIT_RESET_WARN]  = timer_ev.button_reset_warning_flag;
  end

  assign ev_vec = {timer_vec, conv_ev, fault_ev, charge_ev};

  genvar g;
  genvar b;
  generate
    for (g = 0; g < 4; g++)
    begin : g_flag
      assign rd_hit[g] = req.rd && (req.addr == (`CEFM_OFS_CHARGE_FLAGS + 8'(g)));
      // A read clears the flags, but an event in the same cycle survives.
      assign flag_d[g] = ((rd_hit[g] ? 8'h00 : flag_q[g]) | ev_vec[g]) & FLAG_VALID[g];
      always_ff @(posedge clk or posedge reset)
      begin
        if (reset)
          flag_q[g] <= `CEFM_FLAG_RESET;
        else
          flag_q[g] <= flag_d[g];
      end
      if (g < 3)
      begin : g_masked
        assign pend_vec[g] = flag_q[g] & ~mask_q[g];
      end
      else
      begin : g_open
        // The timer flags have no mask in this bank.
        assign pend_vec[g] = flag_q[g];
      end

      chk_group_clear: assert property (
        rd_hit[g] |=> flag_q[g] == ($past(ev_vec[g]) & FLAG_VALID[g]))
        else $error("Flag group not cleared by read.");
      chk_group_sticky: assert property (
        !rd_hit[g] |=> (flag_q[g] & $past(flag_q[g])) == $past(flag_q[g]))
        else $error("Flag dropped without read.");
      chk_group_reserved: assert property (
        (flag_q[g] & ~FLAG_VALID[g]) == 8'h00)
        else $error("Reserved flag bit set.");

      for (b = 0; b < 8; b++)
      begin : g_bit
        if (FLAG_VALID[g][b])
        begin : g_live
          chk_bit_set: assert property (
            ev_vec[g][b] |=> flag_q[g][b])
            else $error("Event did not set its flag.");
        end
      end
    end
  endgenerate

  // ********************************************************
  // Mask registers.
  // ********************************************************
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      mask_q[0] <= `CEFM_CHARGE_MASK_RST;
      mask_q[1] <= `CEFM_FAULT_MASK_RST;
      mask_q[2] <= `CEFM_CONV_MASK_RST;
    end
    else if (req.wr)
    begin
      case (req.addr)
        `CEFM_OFS_CHARGE_MASKS: mask_q[0] <= req.wdata;
        `CEFM_OFS_FAULT_MASKS:  mask_q[1] <= req.wdata;
        `CEFM_OFS_CONV_MASKS:   mask_q[2] <= req.wdata;
        default:                mask_q[0] <= mask_q[0];
      endcase
    end
  end

  // ********************************************************
  // Read port.
  // ********************************************************
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rvalid_q <= req.rd;
      if (req.rd)
      begin
        case (req.addr)
          `CEFM_OFS_CHARGE_FLAGS: rdata_q <= flag_q[0];
          `CEFM_OFS_FAULT_FLAGS:  rdata_q <= flag_q[1];
          `CEFM_OFS_CONV_FLAGS:   rdata_q <= flag_q[2];
          `CEFM_OFS_TIMER_FLAGS:  rdata_q <= flag_q[3];
          `CEFM_OFS_CHARGE_MASKS: rdata_q <= mask_q[0];
          `CEFM_OFS_FAULT_MASKS:  rdata_q <= mask_q[1];
          `CEFM_OFS_CONV_MASKS:   rdata_q <= mask_q[2];
          default:                rdata_q <= 8'h00;
        endcase
      end
    end
  end

  // ********************************************************
  // Interrupt request.
  // ********************************************************
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      irq_q <= 1'b0;
    else
      irq_q <= irq_d;
  end

  // Interrupt sum over every unmasked flag.
  always_comb
  begin
    irq_d = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      irq_d = irq_d | (|pend_vec[i]);
    end
  end

  // ********************************************************
  // Checks.
  // ********************************************************
  chk_read_clears: assert property (
    req.rd && req.addr == `CEFM_OFS_TIMER_FLAGS
    |=> flag_q[3] == ($past(timer_vec) & `CEFM_TIMER_VALID))
    else $error("Timer flags not cleared by read.");
  chk_watchdog_set: assert property (
    timer_ev.watchdog_expired_flag |=> flag_q[3][`CEFM_BIT_WATCHDOG])
    else $error("Watchdog flag not set.");
  chk_safety_set: assert property (
    timer_ev.safety_timer_expired_flag |=> flag_q[3][`CEFM_BIT_SAFETY])
    else $error("Safety timer flag not set.");
  chk_overcurrent_set: assert property (
    timer_ev.regulator_overcurrent_flag |=> flag_q[3][`CEFM_BIT_REG_OC])
    else $error("Regulator overcurrent flag not set.");
  chk_wake_first_set: assert property (
    timer_ev.button_wake_first_flag |=> flag_q[3][`CEFM_BIT_WAKE_FIRST])
    else $error("First wake flag not set.");
  chk_wake_second_set: assert property (
    timer_ev.button_wake_second_flag |=> flag_q[3][`CEFM_BIT_WAKE_SECOND])
    else $error("Second wake flag not set.");
  chk_reset_warn_set: assert property (
    timer_ev.button_reset_warning_flag |=> flag_q[3][`CEFM_BIT_RESET_WARN])
    else $error("Reset warning flag not set.");
  chk_flag_sticky: assert property (
    flag_q[3][`CEFM_BIT_WATCHDOG] && !req.rd |=> flag_q[3][`CEFM_BIT_WATCHDOG])
    else $error("Watchdog flag dropped without read.");
  chk_mask_write: assert property (
    req.wr && req.addr == `CEFM_OFS_CHARGE_MASKS |=> mask_q[0] == $past(req.wdata))
    else $error("Charge mask write lost.");
  chk_mask_reset_value: assert property (
    @(posedge clk) $fell(reset) |-> mask_q[2] == `CEFM_CONV_MASK_RST)
    else $error("Converter mask reset value wrong.");
  chk_irq_masking: assert property (
    ##1 irq_q == $past(|(flag_q[0] & ~mask_q[0]) || |(flag_q[1] & ~mask_q[1])
      || |(flag_q[2] & ~mask_q[2]) || |flag_q[3]))
    else $error("Interrupt does not follow unmasked flags.");
  chk_reserved_zero: assert property (
    flag_q[2][3:1] == 3'b000 && flag_q[3][7] == 1'b0 && flag_q[3][3] == 1'b0)
    else $error("Reserved flag bit set.");
  chk_irq_timer_flag: assert property (
    |flag_q[3] |=> irq_q)
    else $error("Timer flag did not raise interrupt.");

  // ********************************************************
  // Register port checks.
  // ********************************************************
  chk_fault_mask_write: assert property (
    req.wr && req.addr == `CEFM_OFS_FAULT_MASKS |=> mask_q[1] == $past(req.wdata))
    else $error("Fault mask write lost.");
  chk_conv_mask_write: assert property (
    req.wr && req.addr == `CEFM_OFS_CONV_MASKS |=> mask_q[2] == $past(req.wdata))
    else $error("Converter mask write lost.");
  chk_mask_hold: assert property (
    !req.wr |=> mask_q[0] == $past(mask_q[0]) && mask_q[1] == $past(mask_q[1])
      && mask_q[2] == $past(mask_q[2]))
    else $error("Mask changed without write.");
  chk_rvalid_pulse: assert property (
    ##1 rvalid_q == $past(req.rd))
    else $error("Read valid does not follow read strobe.");
  chk_rdata_hold: assert property (
    !req.rd |=> $stable(rdata_q))
    else $error("Read data changed without read.");
  chk_timer_read_data: assert property (
    req.rd && req.addr == `CEFM_OFS_TIMER_FLAGS |=> rdata_q == $past(flag_q[3]))
    else $error("Timer flag read data wrong.");
  chk_charge_read_data: assert property (
    req.rd && req.addr == `CEFM_OFS_CHARGE_FLAGS |=> rdata_q == $past(flag_q[0]))
    else $error("Charge flag read data wrong.");
  chk_fault_read_data: assert property (
    req.rd && req.addr == `CEFM_OFS_FAULT_FLAGS |=> rdata_q == $past(flag_q[1]))
    else $error("Fault flag read data wrong.");
  chk_conv_read_data: assert property (
    req.rd && req.addr == `CEFM_OFS_CONV_FLAGS |=> rdata_q == $past(flag_q[2]))
    else $error("Converter flag read data wrong.");
  chk_charge_mask_read: assert property (
    req.rd && req.addr == `CEFM_OFS_CHARGE_MASKS |=> rdata_q == $past(mask_q[0]))
    else $error("Charge mask read data wrong.");
  chk_fault_mask_read: assert property (
    req.rd && req.addr == `CEFM_OFS_FAULT_MASKS |=> rdata_q == $past(mask_q[1]))
    else $error("Fault mask read data wrong.");
  chk_conv_mask_read: assert property (
    req.rd && req.addr == `CEFM_OFS_CONV_MASKS |=> rdata_q == $past(mask_q[2]))
    else $error("Converter mask read data wrong.");
  chk_unmapped_zero: assert property (
    req.rd && (req.addr < `CEFM_OFS_CHARGE_FLAGS || req.addr > `CEFM_OFS_CONV_MASKS)
    |=> rdata_q == 8'h00)
    else $error("Unmapped offset read nonzero.");
  chk_flag_write_ignored: assert property (
    req.wr && !req.rd && timer_vec == 8'h00 |=> flag_q[3] == $past(flag_q[3]))
    else $error("Write changed timer flags.");
  chk_reset_values: assert property (
    @(posedge clk) disable iff (1'b0)
    reset |-> mask_q[0] == `CEFM_CHARGE_MASK_RST && mask_q[1] == `CEFM_FAULT_MASK_RST
      && mask_q[2] == `CEFM_CONV_MASK_RST && !irq_q && !rvalid_q)
    else $error("Reset values wrong.");

  // ********************************************************
  // Cover points.
  // ********************************************************
  cov_watchdog_irq: cover property (timer_ev.watchdog_expired_flag ##2 irq_q);
  cov_masked_event: cover property (conv_ev[6] && mask_q[2][6] ##1 flag_q[2][6]);
  cov_set_on_clear: cover property (req.rd && req.addr == `CEFM_OFS_TIMER_FLAGS && |timer_vec);
  cov_fault_masked: cover property (fault_ev[7] && mask_q[1][7] ##1 flag_q[1][7]);
  cov_conv_unmask: cover property (req.wr && req.addr == `CEFM_OFS_CONV_MASKS);

endmodule
`default_nettype wire

// file: sim/cefm_host.sv
// Host model that issues single-byte register reads and writes.
`default_nettype none
module cefm_host
  import cefm_pkg::*;
(
  // Clock.
  input  wire logic       clk,
  // Register access.
  output var  cefm_req_t  req,
  input  wire logic [7:0] rdata_q,
  input  wire logic       rvalid_q
);
  timeunit 1ns;
  timeprecision 1ns;
  initial req = '0;
  // One access; a read returns X when no valid byte came back.
  task automatic acc(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    @(negedge clk);
    req <= '{~w, w, a, d};
    @(negedge clk);
    q = (rvalid_q === 1'b1) ? rdata_q : 8'hxx;
    req <= '{1'b0, 1'b0, ~a, ~d};
  endtask
endmodule
`default_nettype wire

// file: sim/testbench.sv
// Self-checking bench for the charger event flag and mask bank.
`include "cefm_consts.svh"
`default_nettype none
module testbench
  import cefm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic           clk, reset, rvalid_q, irq_q;
  logic [7:0]     charge_ev, fault_ev, conv_ev, rdata_q, v;
  cefm_timer_ev_t timer_ev;
  cefm_req_t      req;
  int             bad_count, samples_checked;
  int             p [6] = '{0, 1, 2, 4, 5, 6};
  cefm_bank dut_u (.clk(clk), .reset(reset), .req(req), .rdata_q(rdata_q),
    .rvalid_q(rvalid_q), .charge_ev(charge_ev), .fault_ev(fault_ev), .conv_ev(conv_ev),
    .timer_ev(timer_ev), .irq_q(irq_q));
  cefm_host host_u (.clk(clk), .req(req), .rdata_q(rdata_q), .rvalid_q(rvalid_q));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic give_verdict();
    if (bad_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, g);
    samples_checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rd(input logic [7:0] a, e);
    host_u.acc(1'b0, a, 8'h00, v);
    chk("rdata", e, v);
  endtask
  task automatic wr(input logic [7:0] a, d);
    logic [7:0] q;
    host_u.acc(1'b1, a, d, q);
  endtask
  task automatic ev(input logic [5:0] t, input logic [7:0] c, f, k);
    @(negedge clk);
    timer_ev <= cefm_timer_ev_t'(t);
    charge_ev <= c;
    fault_ev <= f;
    conv_ev <= k;
    @(negedge clk);
    timer_ev <= '0;
    charge_ev <= 8'h00;
    fault_ev <= 8'h00;
    conv_ev <= 8'h00;
  endtask
  task automatic irq_is(input logic e);
    repeat (2) @(negedge clk);
    chk("irq", {7'h00, e}, {7'h00, irq_q});
  endtask
  initial
  begin
    void'($urandom(1));
    bad_count = 0;
    samples_checked = 0;
    reset = 1'b1;
    timer_ev = '0;
    charge_ev = 8'h00;
    fault_ev = 8'h00;
    conv_ev = 8'h00;
    repeat (3) @(negedge clk);
    reset = 1'b0;
    rd(`CEFM_OFS_TIMER_FLAGS, 8'h00);
    rd(`CEFM_OFS_CHARGE_MASKS, 8'h00);
    rd(`CEFM_OFS_FAULT_MASKS, 8'h00);
    rd(`CEFM_OFS_CONV_MASKS, 8'h71);
    for (int i = 0; i < 6; i++)
    begin
      ev(6'(1 << i), 8'h00, 8'h00, 8'h00);
      irq_is(1'b1);
      wr(`CEFM_OFS_TIMER_FLAGS, 8'h00);
      rd(`CEFM_OFS_TIMER_FLAGS, 8'h01 << p[i]);
      rd(`CEFM_OFS_TIMER_FLAGS, 8'h00);
      irq_is(1'b0);
    end
    for (int k = 0; k < 6; k++)
    begin
      v = 8'($urandom);
      wr(8'(7 + k % 3), v);
      rd(8'(7 + k % 3), v);
    end
    rd(8'h0F, 8'h00);
    wr(`CEFM_OFS_CHARGE_MASKS, 8'hFF);
    ev(6'h00, 8'h41, 8'h00, 8'h00);
    irq_is(1'b0);
    wr(`CEFM_OFS_CHARGE_MASKS, 8'h00);
    irq_is(1'b1);
    rd(`CEFM_OFS_CHARGE_FLAGS, 8'h41);
    rd(`CEFM_OFS_CHARGE_FLAGS, 8'h00);
    wr(`CEFM_OFS_CONV_MASKS, 8'hFF);
    wr(`CEFM_OFS_FAULT_MASKS, 8'hFF);
    ev(6'h00, 8'h00, 8'hFF, 8'h00);
    irq_is(1'b0);
    wr(`CEFM_OFS_FAULT_MASKS, 8'h7F);
    irq_is(1'b1);
    rd(`CEFM_OFS_FAULT_FLAGS, 8'hBF);
    irq_is(1'b0);
    reset = 1'b1;
    @(negedge clk);
    reset = 1'b0;
    ev(6'h00, 8'h00, 8'h00, 8'h71);
    irq_is(1'b0);
    rd(`CEFM_OFS_CONV_FLAGS, 8'h71);
    ev(6'h00, 8'h00, 8'h00, 8'h80);
    irq_is(1'b1);
    rd(`CEFM_OFS_CONV_FLAGS, 8'h80);
    irq_is(1'b0);
    give_verdict();
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    bad_count++;
    give_verdict();
  end
endmodule
`default_nettype wire
